/* rtl/state_register_write_decode.sv */
// Decoder and executor of the write-state-register instruction, with an AHB-Lite register slave.
// Assumes a single issue pipeline presenting one instruction at a time and a state register file
// that applies the committed write, masking it to the target's writable fields.
// Assumes issue fields stay stable while issue_valid is high.
// Assumes a bus master that leaves an idle cycle after each single transfer.
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "wrstate_regs.svh"

module state_register_write_decode (
  input wire logic clk, // Core clock, 100 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic issue_valid, // Instruction presented
  output logic issue_ready, // Instruction taken when both high
  input wire wrstate_pkg::issue_t issue, // Instruction word and operands
  input wire wrstate_pkg::proc_state_t proc_state, // Privilege and fp enable state
  input wire logic fp_pending, // Floating-point operations outstanding
  output logic commit_valid, // One-cycle write strobe
  output wrstate_pkg::commit_t commit, // Target and write value
  output logic trap_valid, // One-cycle trap report
  output wrstate_pkg::trap_t trap_code, // Trap kind
  output logic software_reset_instruction, // One-cycle software reset request
  output logic [`SOFTINT_WIDTH-1:0] soft_interrupt, // Soft interrupt register
  input wire logic hsel, // AHB-Lite slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Word transfers only
  input wire logic hready, // Bus ready in
  input wire logic [31:0] hwdata, // Write data
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Never waits
  output logic hresp, // Always OKAY
  output logic irq // Level interrupt
);

  // Reserved destination numbers; 15 is left to the trap logic since one form of it is legal
  function automatic logic is_reserved(input logic [4:0] dst);
    is_reserved = (dst == 5'h01) || (dst == 5'h04) || (dst == 5'h05)
      || ((dst >= 5'h07) && (dst <= 5'h0E)) || (dst >= 5'h1A);
  endfunction

  // Destinations that need privilege to write
  // Perf counters are not listed: their guard also depends on the user lock
  function automatic logic is_priv_only(input logic [4:0] dst);
    is_priv_only = (dst == 5'h10) || (dst == 5'h12) || ((dst >= 5'h14) && (dst <= 5'h19));
  endfunction

  // Targets whose new value the very next word must see
  function automatic logic is_serialising(input logic [4:0] code);
    is_serialising = (code == 5'h02) || (code == 5'h03) || (code == 5'h06);
  endfunction

  logic [31:0] ctrl;
  logic [`EVENT_WIDTH-1:0] event_status;
  logic [`EVENT_WIDTH-1:0] event_mask;
  logic [`EVENT_WIDTH-1:0] event_set;
  logic serial_hold;

  // Instruction fields
  logic [1:0] op;
  logic [4:0] dst;
  logic [5:0] opcode_extension_field;
  logic [4:0] source_one_field;
  logic imm_select;
  logic [`SIMM_WIDTH-1:0] signed_immediate_field;
  assign op = issue.instr[31:30];
  assign dst = issue.instr[29:25];
  assign opcode_extension_field = issue.instr[24:19];
  assign source_one_field = issue.instr[18:14];
  assign imm_select = issue.instr[13];
  assign signed_immediate_field = issue.instr[12:0];
  // Only the fp stall on issue_ready acts on these fields before a word is taken

  logic is_wrstate;
  logic is_ancillary;
  logic is_sw_reset;
  logic [63:0] write_value;
  assign is_wrstate = (op == `OP_FORMAT3) && (opcode_extension_field == `OPCODE_EXT_WRSTATE);
  assign is_ancillary = is_wrstate && (dst >= `DST_ANCILLARY_BASE);
  assign is_sw_reset = is_wrstate && (dst == `DST_SW_RESET)
    && (source_one_field == 5'h00) && imm_select;
  // Operand is the sign-extended immediate or the second source
  // Worked out for every word; only a taken legal write lets it out
  assign write_value = issue.src_one ^ (imm_select
    ? {{(64-`SIMM_WIDTH){signed_immediate_field[`SIMM_WIDTH-1]}}, signed_immediate_field}
    : issue.src_two);

  // Trap selection; reserved numbers first, then fp enable, then privilege
  // One verdict per word: the first match in this order wins
  // The reset form of 15 is a legal word and gets no trap
  wrstate_pkg::trap_t next_trap;
  always_comb begin
    next_trap = wrstate_pkg::TRAP_NONE;
    if (is_wrstate) begin
      if (dst == `DST_SW_RESET) begin
        // Other rd=15 encodings have no defined meaning here
        if (!is_sw_reset) begin
          next_trap = wrstate_pkg::TRAP_ILLEGAL;
        end
      end else if (is_reserved(dst)) begin
        next_trap = wrstate_pkg::TRAP_ILLEGAL;
      end else if (dst == 5'h13) begin
        if (!proc_state.proc_state_fp_enable || !proc_state.status_reg_fp_enable_bit) begin
          next_trap = wrstate_pkg::TRAP_FP_DISABLED;
        end
      end else if (dst == 5'h11) begin
        if (!proc_state.proc_state_privileged && proc_state.counter_user_lock_bit) begin
          next_trap = wrstate_pkg::TRAP_PRIV_ACTION;
        end
      end else if (is_priv_only(dst) && !proc_state.proc_state_privileged) begin
        // Perf control and the other privileged ancillaries alike
        next_trap = wrstate_pkg::TRAP_PRIV_OPCODE;
      end
    end
  end

  // Stall an fp status write behind pending fp work; hold after a non-delayed write
  // A stalled status write holds back every later word too, which keeps program order
  // Ready looks at the offered word even while valid is low; harmless, nothing is taken
  logic fp_stall;
  assign fp_stall = is_wrstate && (dst == 5'h06) && fp_pending;
  assign issue_ready = ctrl[`CTRL_ENABLE_BIT] && !fp_stall && !serial_hold;

  // Handshake and the decision to write
  logic take;
  logic does_write;
  assign take = issue_valid && issue_ready;
  // Write only when decoded, legal and not the reset encoding
  // The reset encoding is taken and reported but writes no register
  assign does_write = take && is_wrstate && (next_trap == wrstate_pkg::TRAP_NONE)
    && (dst != `DST_SW_RESET);

  // Commit port; routing is by target code equal to destination
  // Target and data hold between writes; only the strobe marks a new one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      commit_valid <= 1'b0;
      commit <= '0;
    end else begin
      commit_valid <= does_write;
      if (does_write) begin
        commit.target <= wrstate_pkg::target_t'(dst);
        commit.data <= write_value;
      end
    end
  end

  // Serialise after ccr, asi or fp status so the follower sees the value
  // One bubble per such write, cheaper than forwarding the new value to the issue side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_hold <= 1'b0;
    end else begin
      serial_hold <= does_write && is_serialising(dst);
    end
  end

  // Trap report, one per taken instruction that traps, in issue order
  // trap_code keeps the last verdict so software can read it back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trap_valid <= 1'b0;
      trap_code <= wrstate_pkg::TRAP_NONE;
      software_reset_instruction <= 1'b0;
    end else begin
      trap_valid <= take && (next_trap != wrstate_pkg::TRAP_NONE);
      if (take) begin
        trap_code <= next_trap;
      end
      software_reset_instruction <= take && is_sw_reset;
    end
  end

  // Soft interrupt register kept here since set and clear need its old value
  // Bits above the register width are not writable and are dropped
  logic [`SOFTINT_WIDTH-1:0] softint_value;
  assign softint_value = write_value[`SOFTINT_WIDTH-1:0];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_interrupt <= `SOFTINT_RESET;
    end else if (does_write && is_ancillary) begin
      unique case (dst)
        5'h14: soft_interrupt <= soft_interrupt | softint_value;
        5'h15: soft_interrupt <= soft_interrupt & ~softint_value;
        5'h16: soft_interrupt <= softint_value;
        default: soft_interrupt <= soft_interrupt;
      endcase
    end
  end

  // Events for the interrupt status
  always_comb begin
    event_set = '0;
    if (take) begin
      event_set[`EV_ILLEGAL] = (next_trap == wrstate_pkg::TRAP_ILLEGAL);
      event_set[`EV_FP_DISABLED] = (next_trap == wrstate_pkg::TRAP_FP_DISABLED);
      event_set[`EV_PRIV_OPCODE] = (next_trap == wrstate_pkg::TRAP_PRIV_OPCODE);
      event_set[`EV_PRIV_ACTION] = (next_trap == wrstate_pkg::TRAP_PRIV_ACTION);
      event_set[`EV_SW_RESET] = is_sw_reset;
    end
  end

  // AHB-Lite address phase capture; a write lands at the end of its data phase
  // hsize and the byte lanes are ignored: only whole aligned words are expected
  logic wr_pend;
  logic [7:0] wr_addr;
  logic addr_take;
  assign addr_take = hsel && htrans[1] && hready;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_take && hwrite;
      if (addr_take) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  // Control register steers whether instructions are accepted
  // Clearing the enable stops new words; a word already taken still answers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `CTRL_RESET;
      event_mask <= `EVENT_RESET;
    end else if (wr_pend) begin
      if (wr_addr == `ADDR_CTRL) begin
        ctrl <= {31'h00000000, hwdata[`CTRL_ENABLE_BIT]};
      end
      if (wr_addr == `ADDR_EVENT_MASK) begin
        event_mask <= hwdata[`EVENT_WIDTH-1:0];
      end
    end
  end

  // Sticky status, write one to clear; a new event wins over its clear
  // Losing an event to a clear in the same cycle would hide a trap from software
  logic [`EVENT_WIDTH-1:0] status_clear;
  assign status_clear = (wr_pend && (wr_addr == `ADDR_EVENT_STATUS)) ? hwdata[`EVENT_WIDTH-1:0] : '0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_status <= `EVENT_RESET;
    end else begin
      event_status <= (event_status & ~status_clear) | event_set;
    end
  end
  // Level interrupt while any unmasked event is pending
  assign irq = |(event_status & event_mask);

  // Register map, one aligned word each:
  //   0x00 control, bit 0 lets instructions in, set out of reset
  //   0x04 event status, sticky, write one to clear
  //   0x08 event mask, same layout as the status
  //   0x0C soft interrupt register, read only
  //   0x10 verdict of the last taken word, read only
  function automatic logic [31:0] read_word(input logic [7:0] addr);
    unique case (addr)
      `ADDR_CTRL: read_word = ctrl;
      `ADDR_EVENT_STATUS: read_word = {{(32-`EVENT_WIDTH){1'b0}}, event_status};
      `ADDR_EVENT_MASK: read_word = {{(32-`EVENT_WIDTH){1'b0}}, event_mask};
      `ADDR_SOFTINT: read_word = {{(32-`SOFTINT_WIDTH){1'b0}}, soft_interrupt};
      `ADDR_LAST_TRAP: read_word = {29'h00000000, trap_code};
      default: read_word = 32'h00000000;
    endcase
  endfunction

  // Read data is taken at the address phase and stands from a flip-flop through the data phase;
  // a read placed straight after a write, with no idle cycle, sees the value before that write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (addr_take && !hwrite) begin
      hrdata <= read_word(haddr[7:0]);
    end
  end

  // Zero wait states, so no stall is ever inserted
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

`default_nettype wire

/* rtl/wrstate_regs.svh */
// Constants for the state register write decoder: encodings, bus offsets, reset values.
// Assumes inclusion by the decoder module and its bench, at most once per file.
`ifndef WRSTATE_REGS_SVH
`define WRSTATE_REGS_SVH
// Instruction encoding
`define OP_FORMAT3 2'h2
`define OPCODE_EXT_WRSTATE 6'h30
`define DST_SW_RESET 5'h0F
`define DST_ANCILLARY_BASE 5'h10
`define SIMM_WIDTH 13
// Soft interrupt register
`define SOFTINT_WIDTH 17
`define SOFTINT_RESET 17'h00000
// Bus register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_EVENT_STATUS 8'h04
`define ADDR_EVENT_MASK 8'h08
`define ADDR_SOFTINT 8'h0C
`define ADDR_LAST_TRAP 8'h10
// Control and event fields
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 32'h00000001
`define EVENT_WIDTH 5
`define EV_ILLEGAL 0
`define EV_FP_DISABLED 1
`define EV_PRIV_OPCODE 2
`define EV_PRIV_ACTION 3
`define EV_SW_RESET 4
`define EVENT_RESET 5'h00
`endif

/* rtl/wrstate_pkg.sv */
// Types shared by the state register write decoder and its bench.
// Assumes nothing of its surroundings; the constants live in their own header.
`default_nettype none
package wrstate_pkg;
  // Target codes equal the destination field value
  typedef enum logic [4:0] {
    TGT_UPPER_DIVIDEND = 5'h00, TGT_CCR = 5'h02, TGT_ASI = 5'h03, TGT_FP_STATUS = 5'h06,
    TGT_PERF_CONTROL = 5'h10, TGT_PERF_COUNTERS = 5'h11, TGT_DISPATCH_CONTROL = 5'h12,
    TGT_GRAPHICS_STATE = 5'h13, TGT_SOFTINT_SET = 5'h14, TGT_SOFTINT_CLEAR = 5'h15,
    TGT_SOFTINT = 5'h16, TGT_TICK_COMPARE = 5'h17, TGT_SYSTEM_TICK = 5'h18,
    TGT_SYSTEM_TICK_COMPARE = 5'h19
  } target_t;
  typedef enum logic [2:0] {
    TRAP_NONE = 3'b000, TRAP_ILLEGAL = 3'b001, TRAP_FP_DISABLED = 3'b010,
    TRAP_PRIV_OPCODE = 3'b011, TRAP_PRIV_ACTION = 3'b100
  } trap_t;
  typedef struct packed {
    logic [31:0] instr;
    logic [63:0] src_one;
    logic [63:0] src_two;
  } issue_t;
  typedef struct packed {
    logic proc_state_privileged;
    logic proc_state_fp_enable;
    logic status_reg_fp_enable_bit;
    logic counter_user_lock_bit;
  } proc_state_t;
  typedef struct packed {
    target_t target;
    logic [63:0] data;
  } commit_t;
endpackage
`default_nettype wire

/* verif/wrstate_props.sv */
// Assertions on the write decoder's instruction port.
// Assumes the bind below onto the decoder's top ports.
`timescale 1ns/1ns
`default_nettype none
module wrstate_props (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic issue_valid, // Offered
  input wire logic issue_ready, // Taken
  input wire wrstate_pkg::issue_t issue, // Word
  input wire wrstate_pkg::proc_state_t proc_state, // Modes
  input wire logic fp_pending, // Fp busy
  input wire logic commit_valid, // Write
  input wire wrstate_pkg::commit_t commit, // Result
  input wire logic trap_valid, // Trap
  input wire wrstate_pkg::trap_t trap_code, // Kind
  input wire logic software_reset_instruction, // Reset
  input wire logic [16:0] soft_interrupt // Soft bits
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Fields of the offered word
  wire [31:0] w = issue.instr;
  wire [4:0] rd = w[29:25];
  wire wr = issue_valid && w[31:30] == 2'h2 && w[24:19] == 6'h30;
  wire tk = wr && issue_ready;
  wire pv = proc_state.proc_state_privileged;
  wire [63:0] xv = issue.src_one ^ (w[13] ? {{51{w[12]}}, w[12:0]} : issue.src_two);
  wire [16:0] xl = xv[16:0];
  xor_value_a: assert property (tk && rd == 5'h02 |=> commit.data == $past(xv))
    else $error("bad value");
  target_map_a: assert property (tk && pv && rd inside {5'h00, 5'h03, 5'h06, 5'h12, [5'h15:5'h19]}
    |=> commit_valid && commit.target == $past(rd)) else $error("bad target");
  reserved_trap_a: assert property (tk && rd inside {5'h01, 5'h04, 5'h05, [5'h07:5'h0E], [5'h1A:5'h1F]}
    |=> trap_valid && trap_code == wrstate_pkg::TRAP_ILLEGAL) else $error("no illegal trap");
  sw_reset_a: assert property (tk && rd == 5'h0F && w[18:13] == 6'h01
    |=> software_reset_instruction && !commit_valid) else $error("no reset");
  fp_stall_a: assert property (wr && rd == 5'h06 && fp_pending |-> !issue_ready) else $error("no stall");
  gfx_enable_a: assert property (tk && rd == 5'h13 && !(proc_state[2] && proc_state[1])
    |=> trap_code == wrstate_pkg::TRAP_FP_DISABLED) else $error("no fp trap");
  counter_lock_a: assert property (tk && rd == 5'h11 && !pv && proc_state[0]
    |=> trap_code == wrstate_pkg::TRAP_PRIV_ACTION) else $error("no action trap");
  priv_opcode_a: assert property (tk && !pv && rd inside {5'h10, 5'h12, [5'h14:5'h19]}
    |=> trap_code == wrstate_pkg::TRAP_PRIV_OPCODE && !commit_valid) else $error("no opcode trap");
  soft_set_a: assert property (tk && pv && rd == 5'h14
    |=> soft_interrupt == ($past(soft_interrupt) | $past(xl))) else $error("bad set");
  next_sees_a: assert property (commit_valid && commit.target inside {5'h02, 5'h03, 5'h06}
    |-> !issue_ready) else $error("no hold");
  trap_silent_a: assert property (trap_valid |-> !commit_valid) else $error("trap committed");
  cover property (tk && rd == 5'h0F);
  cover property (trap_valid && trap_code == wrstate_pkg::TRAP_PRIV_ACTION);
  cover property (commit_valid && commit.target == wrstate_pkg::TGT_SOFTINT);
endmodule
bind state_register_write_decode wrstate_props u_props (.clk, .rst, .issue_valid, .issue_ready, .issue,
  .proc_state, .fp_pending, .commit_valid, .commit, .trap_valid, .trap_code, .software_reset_instruction,
  .soft_interrupt);
`default_nettype wire

/* verif/wrstate_partner.sv */
// Issue side model: fp unit busy flag and state register file.
// Assumes the decoder's commit outputs on one clock.
`timescale 1ns/1ns
`default_nettype none
module wrstate_partner #(parameter int FP_LAT = 6) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic fp_launch, // Start fp work
  input wire logic commit_valid, // Write
  input wire wrstate_pkg::commit_t commit, // Result
  output logic fp_pending // Fp work outstanding
);
  int cnt;
  logic [63:0] regs [32];
  // Busy count of fp work, the stall source for status writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cnt <= 0;
    else if (fp_launch)
      cnt <= FP_LAT;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign fp_pending = cnt != 0;
  // Takes each write at once, so the next word sees it
  always_ff @(posedge clk) begin
    if (commit_valid)
      regs[commit.target] <= commit.data;
  end
endmodule
`default_nettype wire

/* verif/tb.sv */
// Bench: decode table, fp stall, bus, interrupt and reset.
// Assumes the decoder, its package, header, partner and checker.
`timescale 1ns/1ns
`default_nettype none
`include "wrstate_regs.svh"
module tb;
  typedef struct packed {logic [3:0] ps; logic [4:0] r1; logic i; logic [12:0] imm; logic [63:0] s1, s2;} row_t;
  // Modes {priv, proc fp, status fp, lock}, fields and operands
  row_t rows [4] = '{'{4'hE, 5'h00, 1'h0, 13'h0000, 64'h0123456789ABCDEF, 64'hFFFF0000FFFF0000},
    '{4'h1, 5'h00, 1'h1, 13'h1FFF, 64'hF0F0F, 64'h0}, '{4'hA, 5'h00, 1'h1, 13'h0ABC, 64'h5555, 64'h0},
    '{4'h6, 5'h03, 1'h1, 13'h0123, 64'h1, 64'h0}};
  logic clk, rst, issue_valid, fp_launch, hsel, hwrite, hready, issue_ready, fp_pending, commit_valid, trap_valid;
  logic software_reset_instruction, hreadyout, hresp, irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [16:0] soft_interrupt, si;
  logic [63:0] xv;
  logic [3:0] e;
  int fails, num_checks, nwait;
  wrstate_pkg::issue_t issue;
  wrstate_pkg::proc_state_t proc_state;
  wrstate_pkg::commit_t commit;
  wrstate_pkg::trap_t trap_code;
  assign hready = hreadyout;
  state_register_write_decode dut (.clk, .rst, .issue_valid, .issue_ready, .issue, .proc_state, .fp_pending,
    .commit_valid, .commit, .trap_valid, .trap_code, .software_reset_instruction, .soft_interrupt, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hready, .hwdata, .hrdata, .hreadyout, .hresp, .irq);
  wrstate_partner p (.clk, .rst, .fp_launch, .commit_valid, .commit, .fp_pending);
  // Core clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Whole run is near 300 cycles; this limit stops it at 20000
  initial begin
    #200000;
    fails++;
    report_and_stop;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [71:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  // Single word transfer; hready and read data are taken at the rising edge that ends each phase
  task ahb(input logic wt, input logic [31:0] a, d);
    @(posedge clk);
    {hsel, htrans, haddr, hwrite} <= {1'h1, 2'h2, a, wt};
    do @(posedge clk); while (hready !== 1'h1);
    {htrans, hwdata} <= {2'h0, d};
    do @(posedge clk); while (hready !== 1'h1);
    rdat = hrdata;
  endtask
  // Offers one word, held until taken; returns in the answer cycle
  task send(input logic [4:0] d, input row_t r);
    logic k;
    @(posedge clk);
    {issue_valid, proc_state} <= {1'h1, r.ps};
    issue <= {2'h2, d, 6'h30, r.r1, r.i, r.imm, r.s1, r.s2};
    nwait = 0;
    do begin @(negedge clk); k = issue_ready; nwait++; @(posedge clk); end while (k !== 1'h1);
    issue_valid <= 1'h0;
    @(negedge clk);
  endtask
  function automatic logic [3:0] exp_of(input logic [4:0] d, input row_t r);
    if (d == 5'h0F && r.r1 == 5'h00 && r.i) return 4'h8;
    if (d inside {5'h01, 5'h04, 5'h05, [5'h07:5'h0F], [5'h1A:5'h1F]}) return wrstate_pkg::TRAP_ILLEGAL;
    if (d == 5'h13 && !(r.ps[2] && r.ps[1])) return wrstate_pkg::TRAP_FP_DISABLED;
    if (d == 5'h11 && !r.ps[3] && r.ps[0]) return wrstate_pkg::TRAP_PRIV_ACTION;
    if (d inside {5'h10, 5'h12, [5'h14:5'h19]} && !r.ps[3]) return wrstate_pkg::TRAP_PRIV_OPCODE;
    return 4'h0;
  endfunction
  initial begin
    {rst, issue_valid, fp_launch, hsel, hwrite, htrans, haddr, hwdata, si, fails, num_checks} = '0;
    rst = 1'h1;
    issue = '0;
    proc_state = '0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk({issue_ready, irq, trap_valid, soft_interrupt}, {3'h4, 17'h0});
    $display("reset test done");
    foreach (rows[n]) for (int d = 0; d < 32; d++) begin
      send(d[4:0], rows[n]);
      e = exp_of(d[4:0], rows[n]);
      xv = rows[n].s1 ^ (rows[n].i ? {{51{rows[n].imm[12]}}, rows[n].imm} : rows[n].s2);
      if (e == 4'h0) case (d)
        20: si |= xv[16:0];
        21: si &= ~xv[16:0];
        22: si = xv[16:0];
      endcase
      chk({commit_valid, trap_valid, software_reset_instruction, trap_code}, {e == 0, e[2:0] != 0, e});
      if (e == 4'h0) chk({commit.target, commit.data}, {d[4:0], xv});
      chk(soft_interrupt, si);
    end
    $display("decode table test done");
    ahb(1'h0, `ADDR_LAST_TRAP, 32'h0);
    chk(rdat, 32'h1);
    chk(p.regs[2], 64'h122);
    @(posedge clk);
    fp_launch <= 1'h1;
    @(posedge clk);
    fp_launch <= 1'h0;
    send(5'h06, rows[0]);
    chk(nwait > 3, 1'h1);
    $display("fp stall test done");
    ahb(1'h0, `ADDR_EVENT_STATUS, 32'h0);
    chk({irq, rdat}, 33'h1F);
    ahb(1'h1, `ADDR_EVENT_MASK, 32'h1);
    @(negedge clk);
    chk(irq, 1'h1);
    ahb(1'h1, `ADDR_EVENT_STATUS, 32'h1);
    ahb(1'h0, `ADDR_EVENT_STATUS, 32'h0);
    chk({irq, rdat}, 33'h1E);
    ahb(1'h0, 32'h40, 32'h0);
    chk(rdat, 32'h0);
    chk({hresp, hreadyout}, 2'h1);
    ahb(1'h1, `ADDR_CTRL, 32'h0);
    @(negedge clk);
    chk(issue_ready, 1'h0);
    ahb(1'h0, `ADDR_SOFTINT, 32'h0);
    chk(rdat, si);
    $display("bus and interrupt test done");
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk({soft_interrupt, issue_ready}, 18'h1);
    $display("second reset test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
